// ---- verilog/dscw_pkg.sv ----
// Purpose: Shared constants for the drive status and command word block.
// Assumes: Classic Wishbone slave with 32-bit data and byte addresses.
// Notes: Words are 16 bits wide and sit in the low half of the data bus.
// ==========================================================
// Package
package dscw_pkg;
  // ==========================================================
  // Register map, byte offsets
  localparam logic [3:0] DSCW_OFS_CMD = 4'h0;
  localparam logic [3:0] DSCW_OFS_STAT = 4'h4;
  localparam logic [3:0] DSCW_OFS_MODE = 4'h8;
  localparam logic [15:0] DSCW_CMD_RST = 16'h0000;
  localparam logic [7:0] DSCW_MODE_RST = 8'h00;
  // ==========================================================
  // Command word fields
  localparam int DSCW_CB_SWON = 0;
  localparam int DSCW_CB_ENOP = 3;
  localparam int DSCW_CB_MSLO = 4;
  localparam int DSCW_CB_MSHI = 6;
  localparam int DSCW_CB_FRST = 7;
  localparam int DSCW_CB_HALT = 8;
  // Bits kept in the command word: transition, mode-specific and halt
  localparam logic [15:0] DSCW_TRANS_MASK = 16'h008F;
  localparam logic [15:0] DSCW_OTHER_MASK = 16'h0170;
  // ==========================================================
  // Status word fields
  localparam int DSCW_SB_REMOTE = 9;
  localparam int DSCW_SB_TREACH = 10;
  localparam int DSCW_SB_ILIMIT = 11;
  localparam int DSCW_SB_MODE12 = 12;
  localparam int DSCW_SB_MODE13 = 13;
  // ==========================================================
  // Operating mode codes, signed 8-bit
  localparam logic [7:0] DSCW_M_PROF_POS = 8'h01;
  localparam logic [7:0] DSCW_M_PROF_VEL = 8'h03;
  localparam logic [7:0] DSCW_M_HOMING = 8'h06;
  localparam logic [7:0] DSCW_M_INTERP = 8'h07;
  localparam logic [7:0] DSCW_M_CS_POS = 8'h08;
  localparam logic [7:0] DSCW_M_CS_VEL = 8'h09;
  localparam logic [7:0] DSCW_M_CS_TRQ = 8'h0A;
  localparam logic [7:0] DSCW_M_VEL_A = 8'h8F; // -113
  localparam logic [7:0] DSCW_M_VEL_B = 8'h91; // -111
endpackage

// ---- verilog/dscw_rise.sv ----
// Purpose: Rising edge finder between two successive command words.
// Assumes: Old and new values are presented together with a strobe.
// Notes: Pure combinational; the caller holds the previous value.
`timescale 1ns/1ps
// ==========================================================
// Edge finder
module dscw_rise #(
  parameter int W = 1
) (
  input wire logic [W-1:0] old_val,
  input wire logic [W-1:0] new_val,
  input wire logic stb,
  output logic [W-1:0] rise
);
  // Bit goes from 0 to 1 on an accepted write
  assign rise = (new_val & ~old_val) & {W{stb}};
endmodule

// ---- verilog/dscw_flag.sv ----
// Purpose: Sticky status flag with load, set and clear.
// Assumes: Set and clear are one-cycle pulses in the clock domain.
// Notes: Set wins over clear, so a finishing event is lost only to a load in the same cycle.
`timescale 1ns/1ps
// ==========================================================
// Sticky flag
module dscw_flag (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic load_val,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  logic flag_q;
  logic flag_d;
  // Load first, then set over clear
  assign flag_d = load ? load_val : (set | (flag_q & ~clr));
  // Flag storage
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
  assign q = flag_q;
endmodule

// ---- verilog/dscw_top.sv ----
// Purpose: Status word and command word logic of a servo drive state machine.
// Assumes: The state machine core, limits and profile generators lie outside.
// Notes: Registers are reached over a classic Wishbone slave.
`timescale 1ns/1ps
// ==========================================================
// Top module
module dscw_top
  import dscw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // State machine core
  input wire logic [7:0] core_low_status,
  input wire logic core_transition_busy,
  input wire logic core_op_enabled,
  output logic [4:0] trans_cmd,
  output logic trans_cmd_stb,
  output logic fault_reset_pulse,
  // Motion side
  output logic halt_req,
  output logic [2:0] mode_cmd_bits,
  output logic new_setpoint_pulse,
  output logic homing_start_pulse,
  output logic interp_enable,
  output logic [7:0] active_operating_mode_view,
  input wire logic setpoint_reached,
  input wire logic limit_active,
  input wire logic setpoint_ack_flag,
  input wire logic motor_standstill,
  input wire logic interpolation_active_flag,
  input wire logic cyclic_goal_in_use,
  input wire logic following_error,
  input wire logic homing_done,
  input wire logic homing_fail,
  // Homing retention
  input wire logic abs_encoder_fitted,
  input wire logic retained_homed,
  input wire logic retained_home_err,
  output logic homed_state,
  output logic home_err_state
);
  // ==========================================================
  // Declarations
  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic [15:0] cmd_q;
  logic [15:0] cmd_d;
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic trans_stb_q;
  logic frst_q;
  logic nsp_q;
  logic hstart_q;
  logic boot_q;
  logic bus_req;
  logic wr_take;
  logic sel_cmd;
  logic sel_stat;
  logic sel_mode;
  logic cmd_wr;
  logic mode_wr;
  logic remote;
  logic [15:0] wr_word;
  logic [4:0] old_trans;
  logic [4:0] new_trans;
  logic trans_changed;
  logic cmd_accept;
  logic other_accept;
  logic [15:0] accepted_word;
  logic [15:0] other_word;
  logic [4:0] trans_rise;
  logic [2:0] ms_rise;
  logic mode_is_pp;
  logic mode_is_hm;
  logic mode_is_ip;
  logic mode_is_cs;
  logic mode_is_stand;
  logic mode_is_ferr;
  logic hm_entry;
  logic hm_start;
  logic hm_end;
  logic hm_treach;
  logic boot_load;
  logic [15:0] status_word;
  logic st_treach;
  logic st_b12;
  logic st_b13;
  // ==========================================================
  // Bus decode
  // A request is taken only while ack is low
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_take = bus_req & wb_we_i;
  // Register selects by byte offset
  assign sel_cmd = (wb_adr_i == DSCW_OFS_CMD);
  assign sel_stat = (wb_adr_i == DSCW_OFS_STAT);
  assign sel_mode = (wb_adr_i == DSCW_OFS_MODE);
  // Write strobes; the mode byte needs lane 0
  assign cmd_wr = wr_take & sel_cmd;
  assign mode_wr = wr_take & sel_mode & wb_sel_i[0];
  // Ack follows one cycle after the taking edge
  assign ack_d = bus_req;
  // ==========================================================
  // Command word acceptance
  // Remote drops while the core runs a transition
  assign remote = ~core_transition_busy;
  // Unselected byte lanes keep the stored bits
  assign wr_word = {wb_sel_i[1] ? wb_dat_i[15:8] : cmd_q[15:8],
                    wb_sel_i[0] ? wb_dat_i[7:0] : cmd_q[7:0]};
  // Transition bits of the stored and the written word
  assign old_trans = {cmd_q[DSCW_CB_FRST], cmd_q[DSCW_CB_ENOP:DSCW_CB_SWON]};
  assign new_trans = {wr_word[DSCW_CB_FRST], wr_word[DSCW_CB_ENOP:DSCW_CB_SWON]};
  assign trans_changed = (old_trans != new_trans);
  // Nothing of the write is used without remote
  assign cmd_accept = cmd_wr & remote;
  // Other bits only with unchanged transition bits and operation enabled
  assign other_accept = cmd_accept & ~trans_changed & core_op_enabled;
  assign other_word = other_accept ? (wr_word & DSCW_OTHER_MASK) : (cmd_q & DSCW_OTHER_MASK);
  // Reserved bits 9 to 15 are never stored
  assign accepted_word = (wr_word & DSCW_TRANS_MASK) | other_word;
  // Next values of the command and mode registers
  assign cmd_d = cmd_accept ? accepted_word : cmd_q;
  assign mode_d = mode_wr ? wb_dat_i[7:0] : mode_q;
  // ==========================================================
  // Edge finders on accepted writes
  // Fault reset acts on a 0-to-1 change only
  dscw_rise #(.W(5)) u_trans_rise (
    .old_val(old_trans),
    .new_val(new_trans),
    .stb(cmd_accept),
    .rise(trans_rise)
  );
  // Mode-specific bit 4 is edge sensitive in profile position and homing; interpolation uses its level
  dscw_rise #(.W(3)) u_ms_rise (
    .old_val(cmd_q[DSCW_CB_MSHI:DSCW_CB_MSLO]),
    .new_val(wr_word[DSCW_CB_MSHI:DSCW_CB_MSLO]),
    .stb(other_accept),
    .rise(ms_rise)
  );
  // ==========================================================
  // Mode decode from the displayed mode
  assign mode_is_pp = (mode_q == DSCW_M_PROF_POS);
  assign mode_is_hm = (mode_q == DSCW_M_HOMING);
  assign mode_is_ip = (mode_q == DSCW_M_INTERP);
  assign mode_is_cs = (mode_q == DSCW_M_CS_POS) | (mode_q == DSCW_M_CS_VEL) |
                      (mode_q == DSCW_M_CS_TRQ);
  assign mode_is_stand = (mode_q == DSCW_M_PROF_VEL) | (mode_q == DSCW_M_VEL_A) |
                         (mode_q == DSCW_M_VEL_B);
  // Modes whose bit 13 reports following error
  assign mode_is_ferr = mode_is_pp | (mode_q == DSCW_M_CS_POS);
  // ==========================================================
  // Homing flags
  // Entering homing from another displayed mode
  assign hm_entry = mode_wr & (wb_dat_i[7:0] == DSCW_M_HOMING) & ~mode_is_hm;
  assign hm_start = ms_rise[0] & mode_is_hm;
  assign hm_end = homing_done | homing_fail;
  // Retained results restored once after reset release, only with an absolute encoder fitted
  assign boot_load = ~boot_q & abs_encoder_fitted;
  // Target reached in homing: set at end, cleared on entry or restart
  dscw_flag u_hm_treach (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .load(1'b0),
    .load_val(1'b0),
    .set(hm_end),
    .clr(hm_entry | hm_start),
    .q(hm_treach)
  );
  // Homing attained holds the last result
  dscw_flag u_homed (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .load(boot_load),
    .load_val(retained_homed),
    .set(homing_done),
    .clr(hm_start | homing_fail),
    .q(homed_state)
  );
  // Homing error holds the last result
  dscw_flag u_home_err (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .load(boot_load),
    .load_val(retained_home_err),
    .set(homing_fail),
    .clr(hm_start | homing_done),
    .q(home_err_state)
  );
  // ==========================================================
  // Status word assembly
  // Bit 10 reserved in cyclic modes
  assign st_treach = mode_is_cs ? 1'b0 :
                     (mode_is_hm ? hm_treach : setpoint_reached);
  // Bit 12 by displayed mode, zero where reserved
  assign st_b12 = mode_is_pp ? setpoint_ack_flag :
                  mode_is_stand ? motor_standstill :
                  mode_is_hm ? homed_state :
                  mode_is_ip ? interpolation_active_flag :
                  mode_is_cs ? cyclic_goal_in_use :
                  1'b0;
  // Bit 13 by displayed mode
  assign st_b13 = mode_is_ferr ? following_error :
                  mode_is_hm ? home_err_state :
                  1'b0;
  // Each field at its named position; bits 8, 14 and 15 stay zero
  always_comb begin
    status_word = 16'h0000;
    status_word[$bits(core_low_status)-1:0] = core_low_status;
    status_word[DSCW_SB_REMOTE] = remote;
    status_word[DSCW_SB_TREACH] = st_treach;
    status_word[DSCW_SB_ILIMIT] = limit_active;
    status_word[DSCW_SB_MODE12] = st_b12;
    status_word[DSCW_SB_MODE13] = st_b13;
  end
  // ==========================================================
  // Read data selection
  assign rdat_d = ~bus_req ? rdat_q :
                  sel_cmd ? {16'h0000, cmd_q} :
                  sel_stat ? {16'h0000, status_word} :
                  sel_mode ? {24'h000000, mode_q} :
                  32'h00000000;
  // ==========================================================
  // Bus registers
  // Acknowledge, high for one cycle per request
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end
  // Read data, held after the answer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdat_q <= 32'h00000000;
    end else begin
      rdat_q <= rdat_d;
    end
  end
  // ==========================================================
  // Command and mode registers
  // Stored command word
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_q <= DSCW_CMD_RST;
    end else begin
      cmd_q <= cmd_d;
    end
  end
  // Displayed operating mode
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= DSCW_MODE_RST;
    end else begin
      mode_q <= mode_d;
    end
  end
  // Marks the first cycle after reset release
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_q <= 1'b0;
    end else begin
      boot_q <= 1'b1;
    end
  end
  // ==========================================================
  // Command pulses toward core and motion
  // Transition strobe after an accepted change
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trans_stb_q <= 1'b0;
    end else begin
      trans_stb_q <= cmd_accept & trans_changed;
    end
  end
  // Fault reset on a rising bit only
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      frst_q <= 1'b0;
    end else begin
      frst_q <= trans_rise[4];
    end
  end
  // New set-point in profile position mode
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      nsp_q <= 1'b0;
    end else begin
      nsp_q <= ms_rise[0] & mode_is_pp;
    end
  end
  // Homing start in homing mode
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hstart_q <= 1'b0;
    end else begin
      hstart_q <= hm_start;
    end
  end
  // ==========================================================
  // Outputs
  // Bus answer straight from flip-flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  // Core side commands
  assign trans_cmd = old_trans;
  assign trans_cmd_stb = trans_stb_q;
  assign fault_reset_pulse = frst_q;
  // Halt is held while the stored bit is set
  assign halt_req = cmd_q[DSCW_CB_HALT];
  assign mode_cmd_bits = cmd_q[DSCW_CB_MSHI:DSCW_CB_MSLO];
  // Pulses, the interpolation enable and the displayed mode
  assign new_setpoint_pulse = nsp_q;
  assign homing_start_pulse = hstart_q;
  assign interp_enable = cmd_q[DSCW_CB_MSLO] & mode_is_ip;
  assign active_operating_mode_view = mode_q;
endmodule

// ---- bench/dscw_monitor.sv ----
// Purpose: Port checks for the drive status and command word block.
// Assumes: Command at offset 0x0, status at 0x4, one ack per request.
// Notes: Bound into every dscw_top instance.
`timescale 1ns/1ps
// ==========
// Checker
module dscw_monitor (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic core_transition_busy,
  input wire logic [4:0] trans_cmd,
  input wire logic trans_cmd_stb,
  input wire logic halt_req,
  input wire logic [2:0] mode_cmd_bits,
  input wire logic [7:0] active_operating_mode_view,
  input wire logic limit_active,
  input wire logic following_error
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // Request at its taking edge, and the cyclic mode group
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire cyc_mode = active_operating_mode_view inside {8'h08, 8'h09, 8'h0A};
  sequence stat_rd;
    req && !wb_we_i && wb_adr_i == 4'h4 ##1 wb_ack_o;
  endsequence
  sequence cmd_wr;
    req && wb_we_i && wb_adr_i == 4'h0;
  endsequence
  ack_one_pulse_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not a single pulse after a request");
  remote_bit_a: assert property (stat_rd |-> wb_dat_o[9] == !$past(core_transition_busy))
    else $error("remote bit disagrees with transition busy");
  busy_ignore_a: assert property ((cmd_wr ##0 core_transition_busy) |=>
    $stable(trans_cmd) && $stable(halt_req) && $stable(mode_cmd_bits) && !trans_cmd_stb)
    else $error("command write taken while remote was low");
  limit_bit_a: assert property (stat_rd |-> wb_dat_o[11] == $past(limit_active))
    else $error("internal limit bit wrong");
  reserved_zero_a: assert property (stat_rd |-> wb_dat_o[31:14] == 18'h0 && !wb_dat_o[8])
    else $error("reserved status bit set");
  cyclic_reach_a: assert property ((stat_rd ##0 cyc_mode) |-> !wb_dat_o[10])
    else $error("target reached set in a cyclic mode");
  follow_err_a: assert property ((stat_rd ##0 active_operating_mode_view inside
    {8'h01, 8'h08}) |-> wb_dat_o[13] == $past(following_error))
    else $error("following error bit wrong");
  halt_write_a: assert property ($changed(halt_req) |-> $past(req && wb_we_i))
    else $error("halt changed without a write");
  trans_void_a: assert property (trans_cmd_stb |-> trans_cmd != $past(trans_cmd)
    && halt_req == $past(halt_req) && mode_cmd_bits == $past(mode_cmd_bits))
    else $error("other bits taken with a transition change");
endmodule
bind dscw_top dscw_monitor u_dscw_monitor (
  .sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .core_transition_busy(core_transition_busy), .trans_cmd(trans_cmd),
  .trans_cmd_stb(trans_cmd_stb), .halt_req(halt_req), .mode_cmd_bits(mode_cmd_bits),
  .active_operating_mode_view(active_operating_mode_view), .limit_active(limit_active),
  .following_error(following_error)
);

// ---- bench/dscw_master.sv ----
// Purpose: Master controller model on the classic Wishbone bus.
// Assumes: The slave acks every request, mapped or not.
// Notes: Address and data are inverted while idle so stale values never match.
`timescale 1ns/1ps
// ==========
// Master model
module dscw_master (
  input wire logic sys_clk,
  output logic wb_cyc,
  output logic wb_stb,
  output logic wb_we,
  output logic [3:0] wb_adr,
  output logic [3:0] wb_sel,
  output logic [31:0] wb_dat,
  input wire logic wb_ack,
  input wire logic [31:0] wb_rdat
);
  // Idle bus at time zero
  initial begin
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 4'h0;
    wb_sel = 4'h0;
    wb_dat = 32'h0;
  end
  // One classic cycle, held until ack is seen high
  task automatic xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hF;
    wb_dat <= wd;
    // Ack is sampled at rising edges only; the request stands until it is seen high
    @(posedge sys_clk);
    while (wb_ack !== 1'b1) @(posedge sys_clk);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_adr <= ~adr;
    wb_dat <= ~wd;
  endtask
endmodule

// ---- bench/dscw_top_test.sv ----
// Purpose: Self-checking bench for the drive status and command words.
// Assumes: The master model owns the bus; the bench drives core and motion levels.
// Notes: Status expectations are rebuilt from the mode and the levels.
`timescale 1ns/1ps
// ==========
// Bench top
module dscw_top_test
  import dscw_pkg::*;
;
  localparam logic [3:0] CMD = DSCW_OFS_CMD, ST = DSCW_OFS_STAT, MD = DSCW_OFS_MODE;
  logic sys_clk, rst_b, core_transition_busy, core_op_enabled, hs_pulse, fr_pulse;
  logic nsp_pulse, ip_en;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, halt_req, homed_state, home_err_state;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0] mode_view;
  logic [6:0] lv;
  logic [2:0] mode_cmd_bits, ret;
  logic [1:0] hm;
  int err_count, num_checks, hs_cnt, fr_cnt, nsp_cnt;
  dscw_top u_dscw_top (
    .sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_low_status(8'hA5),
    .core_transition_busy(core_transition_busy), .core_op_enabled(core_op_enabled),
    .trans_cmd(), .trans_cmd_stb(), .fault_reset_pulse(fr_pulse), .halt_req(halt_req),
    .mode_cmd_bits(mode_cmd_bits), .new_setpoint_pulse(nsp_pulse), .homing_start_pulse(hs_pulse),
    .interp_enable(ip_en), .active_operating_mode_view(mode_view), .setpoint_reached(lv[0]),
    .limit_active(lv[1]), .setpoint_ack_flag(lv[2]), .motor_standstill(lv[3]),
    .interpolation_active_flag(lv[4]), .cyclic_goal_in_use(lv[5]), .following_error(lv[6]),
    .homing_done(hm[0]), .homing_fail(hm[1]), .abs_encoder_fitted(ret[0]),
    .retained_homed(ret[1]), .retained_home_err(ret[2]), .homed_state(homed_state),
    .home_err_state(home_err_state)
  );
  dscw_master u_dscw_master (
    .sys_clk(sys_clk), .wb_cyc(wb_cyc_i), .wb_stb(wb_stb_i), .wb_we(wb_we_i),
    .wb_adr(wb_adr_i), .wb_sel(wb_sel_i), .wb_dat(wb_dat_i), .wb_ack(wb_ack_o),
    .wb_rdat(wb_dat_o)
  );
  // Clock and mid-cycle pulse counters
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    hs_cnt += int'(hs_pulse);
    fr_cnt += int'(fr_pulse);
    nsp_cnt += int'(nsp_pulse);
  end
  // ==========
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_dscw_master.xfer(1'b1, a, d, x);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] x;
    u_dscw_master.xfer(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask
  task automatic pulse(input logic [1:0] p);
    @(posedge sys_clk);
    hm <= p;
    @(posedge sys_clk);
    hm <= 2'h0;
  endtask
  task automatic conclude;
    if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Expected status word for a non-homing mode
  function automatic logic [31:0] exp_st(input logic [7:0] m, input logic [6:0] v);
    logic [15:0] s;
    s = 16'h02A5;
    s[10] = !(m inside {8'h08, 8'h09, 8'h0A}) && v[0];
    s[11] = v[1];
    case (m)
      8'h01: s[12] = v[2];
      8'h03, 8'h8F, 8'h91: s[12] = v[3];
      8'h07: s[12] = v[4];
      8'h08, 8'h09, 8'h0A: s[12] = v[5];
      default: s[12] = 1'b0;
    endcase
    s[13] = (m == 8'h01 || m == 8'h08) && v[6];
    return {16'h0, s};
  endfunction
  // ==========
  // Scenarios
  task automatic t_reset;
    rdc(CMD, 32'h0);
    rdc(MD, 32'h0);
    rdc(4'hC, 32'h0);
    wr(ST, 32'hFFFF);
    rdc(ST, 32'h02A5);
    chk(32'(homed_state), 32'h1);
    chk(32'(home_err_state), 32'h0);
  endtask
  task automatic t_cmd;
    wr(CMD, 32'h0006);
    rdc(CMD, 32'h0006);
    wr(CMD, 32'h017F);
    rdc(CMD, 32'h000F);
    wr(CMD, 32'h017F);
    rdc(CMD, 32'h000F);
    @(posedge sys_clk) core_op_enabled <= 1'b1;
    wr(CMD, 32'hFF7F);
    rdc(CMD, 32'h017F);
    chk(32'(halt_req), 32'h1);
    chk(32'(mode_cmd_bits), 32'h7);
    wr(CMD, 32'h008F);
    rdc(CMD, 32'h01FF);
    wr(CMD, 32'h008F);
    rdc(CMD, 32'h008F);
    chk(32'(fr_cnt), 32'h1);
    chk(32'(halt_req), 32'h0);
    wr(CMD, 32'h000F);
  endtask
  task automatic t_busy;
    @(posedge sys_clk) core_transition_busy <= 1'b1;
    wr(CMD, 32'h0106);
    rdc(CMD, 32'h000F);
    rdc(ST, 32'h00A5);
    @(posedge sys_clk) core_transition_busy <= 1'b0;
  endtask
  task automatic t_status;
    logic [7:0] modes [9] = '{8'h01, 8'h03, 8'h8F, 8'h91, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h00};
    logic [6:0] v;
    foreach (modes[i]) for (int p = 0; p < 2; p++) begin
      v = (p == 0) ? 7'h55 : 7'h2A;
      wr(MD, {24'h0, modes[i]});
      @(posedge sys_clk) lv <= v;
      rdc(ST, exp_st(modes[i], v));
      chk({24'h0, mode_view}, {24'h0, modes[i]});
    end
  endtask
  task automatic t_homing;
    @(posedge sys_clk) lv <= 7'h00;
    wr(MD, 32'h06);
    rdc(ST, 32'h12A5);
    wr(CMD, 32'h001F);
    rdc(ST, 32'h02A5);
    chk(32'(hs_cnt), 32'h1);
    pulse(2'h1);
    rdc(ST, 32'h16A5);
    wr(CMD, 32'h000F);
    wr(CMD, 32'h001F);
    rdc(ST, 32'h02A5);
    pulse(2'h2);
    rdc(ST, 32'h26A5);
    wr(MD, 32'h00);
    wr(MD, 32'h06);
    rdc(ST, 32'h22A5);
    wr(CMD, 32'h000F);
    wr(CMD, 32'h001F);
    rdc(ST, 32'h02A5);
    chk(32'(hs_cnt), 32'h3);
  endtask
  task automatic t_modecmd;
    wr(MD, 32'h01);
    wr(CMD, 32'h000F);
    wr(CMD, 32'h001F);
    wr(CMD, 32'h001F);
    chk(32'(nsp_cnt), 32'h1);
    chk(32'(hs_cnt), 32'h3);
    wr(MD, 32'h07);
    chk(32'(ip_en), 32'h1);
    wr(MD, 32'h00);
    chk(32'(ip_en), 32'h0);
  endtask
  // ==========
  // Main sequence and watchdog
  initial begin
    rst_b = 1'b0;
    core_transition_busy = 1'b0;
    core_op_enabled = 1'b0;
    lv = 7'h00;
    hm = 2'h0;
    ret = 3'h3;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_cmd();
    t_busy();
    t_status();
    t_homing();
    t_modecmd();
    conclude();
  end
  initial begin
    #20000;
    err_count++;
    conclude();
  end
endmodule
